// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fast_timer_regs.svh"
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module testbench
	import fast_timer_pkg::*;
;
	logic i_clk, i_rst_n, i_wr, i_rd, i_global_irq_enable, i_fast_tick;
	logic i_vector_ack_a, i_vector_ack_b, i_vector_ack_ovf;
	logic i_loop_locked, i_loop_is_sysclk;
	logic o_irq_compare_a, o_irq_compare_b, o_irq_overflow;
	logic o_loop_enable, o_fast_low_speed;
	logic o_compare_a_pin, o_compare_a_oe, o_compare_b_pin, o_compare_b_oe;
	byte_t i_addr, i_wdata, o_rdata, d;
	int n_errors = 0;
	int check_count = 0;
	byte_t regs[9] = '{`ADDR_LOOP_CSR, `ADDR_TIMER_CTRL, `ADDR_GENERAL_CTRL,
		`ADDR_COUNT, `ADDR_CMP_A, `ADDR_CMP_B, `ADDR_CMP_C, `ADDR_IRQ_MASK,
		`ADDR_IRQ_FLAGS};
	byte_t md[5] = '{8'h30, 8'h20, 8'h10, 8'h10, 8'h00};
	logic [4:0] pn = 5'b00101;
	logic [4:0] oe = 5'b01111;

	fast_timer dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_global_irq_enable(i_global_irq_enable),
		.i_vector_ack_a(i_vector_ack_a), .i_vector_ack_b(i_vector_ack_b),
		.i_vector_ack_ovf(i_vector_ack_ovf), .o_irq_compare_a(o_irq_compare_a),
		.o_irq_compare_b(o_irq_compare_b), .o_irq_overflow(o_irq_overflow),
		.i_fast_tick(i_fast_tick), .i_loop_locked(i_loop_locked),
		.i_loop_is_sysclk(i_loop_is_sysclk), .o_loop_enable(o_loop_enable),
		.o_fast_low_speed(o_fast_low_speed), .o_compare_a_pin(o_compare_a_pin),
		.o_compare_a_oe(o_compare_a_oe), .o_compare_b_pin(o_compare_b_pin),
		.o_compare_b_oe(o_compare_b_oe));

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask : idle

	task automatic wr(input byte_t a, input byte_t v);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	// Read data exist only in the one cycle after the strobe.
	task automatic rd(input byte_t a, output byte_t v);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		v = o_rdata;
	endtask : rd

	task automatic rchk(input byte_t a, input byte_t e);
		byte_t v;
		rd(a, v);
		`CHECK("register", e, v)
	endtask : rchk

	task automatic conclude();
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	initial begin
		#200000;
		n_errors++;
		conclude();
	end

	initial begin
		{i_rst_n, i_wr, i_rd, i_global_irq_enable, i_fast_tick} = 5'h00;
		{i_vector_ack_a, i_vector_ack_b, i_vector_ack_ovf} = 3'h0;
		{i_loop_locked, i_loop_is_sysclk, i_addr, i_wdata} = 18'h00000;
		idle(10);
		i_rst_n <= 1'b1;
		foreach (regs[k]) rchk(regs[k], 8'h00);
		wr(8'h50, 8'hff);
		rchk(8'h50, 8'h00);
		// Mode and force sit in different registers, so mode goes first.
		for (int k = 0; k < 5; k++) begin
			wr(`ADDR_TIMER_CTRL, md[k]);
			wr(`ADDR_GENERAL_CTRL, 8'h04);
			idle(1);
			@(negedge i_clk);
			`CHECK("a_oe", oe[k], o_compare_a_oe)
			if (oe[k]) `CHECK("a_pin", pn[k], o_compare_a_pin)
		end
		// Channel B mode and force share a register, so one write does both.
		wr(`ADDR_GENERAL_CTRL, 8'h38);
		idle(1);
		@(negedge i_clk);
		`CHECK("b_oe", 1'b1, o_compare_b_oe)
		`CHECK("b_pin", 1'b1, o_compare_b_pin)
		rchk(`ADDR_IRQ_FLAGS, 8'h00);
		rchk(`ADDR_GENERAL_CTRL, 8'h30);
		wr(`ADDR_COUNT, 8'h33);
		idle(2);
		wr(`ADDR_GENERAL_CTRL, 8'h02);
		rchk(`ADDR_GENERAL_CTRL, 8'h00);
		rchk(`ADDR_COUNT, 8'h33);
		wr(`ADDR_CMP_A, 8'h33);
		idle(3);
		rchk(`ADDR_IRQ_FLAGS, 8'h00);
		wr(`ADDR_CMP_A, 8'h12);
		wr(`ADDR_CMP_B, 8'h13);
		wr(`ADDR_COUNT, 8'h10);
		wr(`ADDR_IRQ_MASK, 8'hff);
		rchk(`ADDR_IRQ_MASK, 8'h64);
		@(posedge i_clk);
		i_global_irq_enable <= 1'b1;
		wr(`ADDR_TIMER_CTRL, 8'h01);
		idle(10);
		wr(`ADDR_TIMER_CTRL, 8'h00);
		rchk(`ADDR_IRQ_FLAGS, 8'h60);
		`CHECK("irq_a", 1'b1, o_irq_compare_a)
		`CHECK("irq_b", 1'b1, o_irq_compare_b)
		wr(`ADDR_IRQ_FLAGS, 8'h40);
		rchk(`ADDR_IRQ_FLAGS, 8'h20);
		@(posedge i_clk);
		i_vector_ack_b <= 1'b1;
		@(posedge i_clk);
		i_vector_ack_b <= 1'b0;
		idle(2);
		rchk(`ADDR_IRQ_FLAGS, 8'h00);
		`CHECK("irq_b", 1'b0, o_irq_compare_b)
		wr(`ADDR_COUNT, 8'hfd);
		idle(2);
		wr(`ADDR_TIMER_CTRL, 8'h01);
		idle(8);
		wr(`ADDR_TIMER_CTRL, 8'h00);
		rchk(`ADDR_IRQ_FLAGS, 8'h04);
		`CHECK("irq_ovf", 1'b1, o_irq_overflow)
		wr(`ADDR_IRQ_MASK, 8'h60);
		idle(2);
		@(negedge i_clk);
		`CHECK("irq_ovf", 1'b0, o_irq_overflow)
		@(posedge i_clk);
		i_vector_ack_ovf <= 1'b1;
		@(posedge i_clk);
		i_vector_ack_ovf <= 1'b0;
		rchk(`ADDR_IRQ_FLAGS, 8'h00);
		wr(`ADDR_CMP_C, 8'h05);
		wr(`ADDR_COUNT, 8'h00);
		idle(2);
		wr(`ADDR_TIMER_CTRL, 8'h81);
		idle(30);
		wr(`ADDR_TIMER_CTRL, 8'h80);
		rd(`ADDR_COUNT, d);
		`CHECK("count_le_c", 1'b1, d <= 8'h05)
		rchk(`ADDR_IRQ_FLAGS, 8'h00);
		wr(`ADDR_TIMER_CTRL, 8'h00);
		wr(`ADDR_GENERAL_CTRL, 8'h40);
		rchk(`ADDR_GENERAL_CTRL, 8'h40);
		wr(`ADDR_TIMER_CTRL, 8'h01);
		idle(12);
		wr(`ADDR_TIMER_CTRL, 8'h00);
		rchk(`ADDR_IRQ_FLAGS, 8'h04);
		wr(`ADDR_GENERAL_CTRL, 8'h00);
		// Fast select needs the loop enable from an earlier write.
		wr(`ADDR_LOOP_CSR, 8'hff);
		rchk(`ADDR_LOOP_CSR, 8'h82);
		`CHECK("low_speed", 1'b1, o_fast_low_speed)
		`CHECK("loop_en", 1'b1, o_loop_enable)
		@(posedge i_clk);
		i_loop_locked <= 1'b1;
		idle(3);
		// Lock is confirmed before the timer moves to the fast clock.
		rchk(`ADDR_LOOP_CSR, 8'h83);
		wr(`ADDR_LOOP_CSR, 8'hff);
		rchk(`ADDR_LOOP_CSR, 8'h87);
		// Eight fast ticks, halved by low speed and again by select 2.
		wr(`ADDR_COUNT, 8'h20);
		wr(`ADDR_TIMER_CTRL, 8'h02);
		i_fast_tick <= 1'b1;
		idle(8);
		i_fast_tick <= 1'b0;
		wr(`ADDR_TIMER_CTRL, 8'h00);
		rchk(`ADDR_COUNT, 8'h22);
		wr(`ADDR_LOOP_CSR, 8'h00);
		rchk(`ADDR_LOOP_CSR, 8'h01);
		@(posedge i_clk);
		i_loop_is_sysclk <= 1'b1;
		idle(4);
		wr(`ADDR_LOOP_CSR, 8'h80);
		rchk(`ADDR_LOOP_CSR, 8'h03);
		@(posedge i_clk);
		{i_loop_is_sysclk, i_loop_locked} <= 2'b00;
		idle(4);
		wr(`ADDR_LOOP_CSR, 8'h00);
		rchk(`ADDR_LOOP_CSR, 8'h00);
		conclude();
	end
endmodule : testbench

bind fast_timer timer_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_global_irq_enable(i_global_irq_enable),
	.o_irq_compare_a(o_irq_compare_a), .o_irq_compare_b(o_irq_compare_b),
	.o_irq_overflow(o_irq_overflow), .i_loop_is_sysclk(i_loop_is_sysclk),
	.o_loop_enable(o_loop_enable), .o_fast_low_speed(o_fast_low_speed));
`default_nettype wire

// ===== bench/timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "fast_timer_regs.svh"

module timer_monitor (
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_global_irq_enable,
	input wire logic       o_irq_compare_a,
	input wire logic       o_irq_compare_b,
	input wire logic       o_irq_overflow,
	input wire logic       i_loop_is_sysclk,
	input wire logic       o_loop_enable,
	input wire logic       o_fast_low_speed
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_RD_IDLE: assert property (
		!$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
	AST_RD_IRQ_RES: assert property (
		$past(i_rd) && ($past(i_addr) == `ADDR_IRQ_MASK
		|| $past(i_addr) == `ADDR_IRQ_FLAGS) |-> (o_rdata & 8'h9b) == 8'h00)
		else $error("irq register reserved bit set");
	AST_RD_LOOP_RES: assert property (
		$past(i_rd) && $past(i_addr) == `ADDR_LOOP_CSR |-> o_rdata[6:3] == 4'h0)
		else $error("loop register reserved bit set");
	AST_RD_GEN_ZERO: assert property (
		$past(i_rd) && $past(i_addr) == `ADDR_GENERAL_CTRL
		|-> o_rdata[3:1] == 3'h0) else $error("strobe bit read back");
	AST_IRQ_A: assert property (
		o_irq_compare_a |-> $past(i_global_irq_enable))
		else $error("irq a without global enable");
	AST_IRQ_B: assert property (
		o_irq_compare_b |-> $past(i_global_irq_enable))
		else $error("irq b without global enable");
	AST_IRQ_OVF: assert property (
		o_irq_overflow |-> $past(i_global_irq_enable))
		else $error("overflow irq without global enable");
	AST_LOW_SPEED: assert property (
		$rose(o_fast_low_speed) |-> $past(i_wr) && $past(i_wdata[7])
		&& $past(i_addr) == `ADDR_LOOP_CSR) else $error("low speed rose alone");
	AST_LOOP_SYSCLK: assert property (
		i_loop_is_sysclk [*4] |=> o_loop_enable)
		else $error("loop enable low while loop is system clock");
endmodule : timer_monitor
`default_nettype wire

// ===== hdl/compare_output.sv
`timescale 1ns/1ps
`default_nettype none

module compare_output
	import fast_timer_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	input  wire compare_mode_t i_mode,
	input  wire logic          i_pwm,
	input  wire logic          i_match,
	input  wire logic          i_force,
	input  wire logic          i_bottom,
	output var  logic          o_level,
	output var  logic          o_drive
);

	logic level_q;
	logic level_d;
	logic drive_q;
	logic drive_d;
	logic action;

	assign action  = i_match | i_force;
	// In pwm mode only the two upper codes connect the pin.
	assign drive_d = i_pwm ? i_mode[1] : (i_mode != MODE_DISCONNECT);

	always_comb begin
		level_d = level_q;
		if (i_pwm) begin
			if (i_match) begin
				level_d = (i_mode == MODE_SET);
			end else if (i_bottom) begin
				level_d = (i_mode == MODE_CLEAR);
			end
		end else if (action) begin
			case (i_mode)
				MODE_TOGGLE: level_d = ~level_q;
				MODE_CLEAR:  level_d = 1'b0;
				MODE_SET:    level_d = 1'b1;
				default:     level_d = level_q;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level_q <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			level_q <= level_d;
			drive_q <= drive_d;
		end
	end

	assign o_level = level_q;
	assign o_drive = drive_q;

endmodule : compare_output

`default_nettype wire

// ===== hdl/fast_timer.sv
// Added by the designer: the plain strobed port.
`include "fast_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module fast_timer
	import fast_timer_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic i_wr,
	input  wire logic i_rd,
	output var  logic [7:0] o_rdata,
	input  wire logic i_global_irq_enable,
	input  wire logic i_vector_ack_a,
	input  wire logic i_vector_ack_b,
	input  wire logic i_vector_ack_ovf,
	output var  logic o_irq_compare_a,
	output var  logic o_irq_compare_b,
	output var  logic o_irq_overflow,
	input  wire logic i_fast_tick,
	input  wire logic i_loop_locked,
	input  wire logic i_loop_is_sysclk,
	output var  logic o_loop_enable,
	output var  logic o_fast_low_speed,
	output var  logic o_compare_a_pin,
	output var  logic o_compare_a_oe,
	output var  logic o_compare_b_pin,
	output var  logic o_compare_b_oe
);

	function automatic logic presc_tap(input logic [`PRESC_W-1:0] cnt,
	                                   input clock_select_t cs);
		logic [`PRESC_W-1:0] mask;
		mask = (`PRESC_ONE << (cs - `CS_ONE)) - `PRESC_ONE;
		return (cs != `CS_STOP) && ((cnt & mask) == mask);
	endfunction : presc_tap

	byte_t         ctrl_q;
	byte_t         ctrl_d;
	logic          pwm_b_q;
	compare_mode_t mode_b_q;
	compare_mode_t mode_b_d;
	byte_t         cnt_q;
	byte_t         cnt_d;
	byte_t         cmp_a_q, cmp_b_q, cmp_c_q;
	logic [2:0]    mask_q;
	logic          flag_a_q, flag_b_q, flag_ovf_q;
	logic          flag_a_d, flag_b_d, flag_ovf_d;
	logic [2:0]    clr_q;
	logic          match_a_q, match_b_q, match_c_q, ovf_evt_q;
	logic          counted_q;
	logic          counted_d;
	logic          load_pend_q;
	byte_t         load_data_q;
	logic [`PRESC_W-1:0] presc_q;
	logic [`PRESC_W-1:0] presc_d;
	logic          presc_rst_q;
	logic          half_q;
	logic          low_speed_q;
	logic          fast_sel_q;
	logic          loop_en_q;
	logic          locked_meta_q, locked_q;
	logic          sysclk_meta_q, sysclk_q;
	logic          irq_a_q, irq_b_q, irq_ovf_q;
	byte_t         rdata_q;

	logic wr_ctrl, wr_gen, wr_cnt, wr_cmp_a, wr_cmp_b;
	logic wr_cmp_c, wr_mask, wr_flags, wr_loop;
	assign wr_ctrl  = i_wr && (i_addr == `ADDR_TIMER_CTRL);
	assign wr_gen   = i_wr && (i_addr == `ADDR_GENERAL_CTRL);
	assign wr_cnt   = i_wr && (i_addr == `ADDR_COUNT);
	assign wr_cmp_a = i_wr && (i_addr == `ADDR_CMP_A);
	assign wr_cmp_b = i_wr && (i_addr == `ADDR_CMP_B);
	assign wr_cmp_c = i_wr && (i_addr == `ADDR_CMP_C);
	assign wr_mask  = i_wr && (i_addr == `ADDR_IRQ_MASK);
	assign wr_flags = i_wr && (i_addr == `ADDR_IRQ_FLAGS);
	assign wr_loop  = i_wr && (i_addr == `ADDR_LOOP_CSR);

	assign ctrl_d   = wr_ctrl ? i_wdata : ctrl_q;
	assign mode_b_d = wr_gen ?
		compare_mode_t'(i_wdata[`GEN_MODE_B_HI:`GEN_MODE_B_LO]) : mode_b_q;

	// Next-value forwarding lets a force see a mode written with it.
	compare_mode_t mode_a;
	logic          pwm_a;
	logic          pwm_any;
	logic          clear_on_c;
	clock_select_t clk_sel;
	assign mode_a =
		compare_mode_t'(ctrl_d[`CTRL_MODE_A_HI:`CTRL_MODE_A_LO]);
	assign pwm_a      = ctrl_q[`CTRL_PWM_A];
	assign pwm_any    = pwm_a | pwm_b_q;
	assign clear_on_c = ctrl_q[`CTRL_CLEAR_ON_C];
	assign clk_sel    = ctrl_q[`CTRL_CS_HI:`CTRL_CS_LO];

	logic force_a;
	logic force_b;
	assign force_a = wr_gen && i_wdata[`GEN_FORCE_A] && !pwm_a;
	assign force_b = wr_gen && i_wdata[`GEN_FORCE_B] && !pwm_b_q;

	// Low speed passes every second fast tick.
	logic fast_pulse;
	logic src_pulse;
	logic tick;
	assign fast_pulse = i_fast_tick && (!low_speed_q || half_q);
	assign src_pulse  = fast_sel_q ? fast_pulse : 1'b1;
	assign tick       = src_pulse && presc_tap(presc_q, clk_sel);
	assign presc_d    = presc_rst_q ? `PRESC_ZERO :
		(src_pulse ? presc_q + `PRESC_ONE : presc_q);

	// Synchronous mode waits one extra cycle for the crossing.
	logic  load_now;
	byte_t load_val;
	assign load_now = (wr_cnt && fast_sel_q) || load_pend_q;
	assign load_val = load_pend_q ? load_data_q : i_wdata;

	logic at_top;
	logic wrap_on_c;
	logic ovf_evt;
	assign at_top    = (cnt_q == `COUNT_TOP);
	assign wrap_on_c = (clear_on_c || pwm_any) && (cnt_q == cmp_c_q);
	assign ovf_evt   = tick && !load_now && at_top && !pwm_any;

	always_comb begin
		cnt_d     = cnt_q;
		counted_d = 1'b0;
		if (load_now) begin
			cnt_d = load_val;
		end else if (tick) begin
			counted_d = 1'b1;
			if (wrap_on_c) begin
				cnt_d = `BYTE_ZERO;
			end else begin
				cnt_d = cnt_q + `COUNT_ONE;
			end
		end
	end

	// A loaded value never counts as counting into a compare value.
	logic match_a, match_b, match_c, bottom;
	assign match_a = counted_q && (cnt_q == cmp_a_q);
	assign match_b = counted_q && (cnt_q == cmp_b_q);
	assign match_c = counted_q && (cnt_q == cmp_c_q);
	assign bottom  = counted_q && (cnt_q == `BYTE_ZERO);

	logic ovf_set;
	assign ovf_set = pwm_any ? match_c_q : ovf_evt_q;

	// Set wins over both the vector acknowledge and the software clear.
	assign flag_a_d = match_a_q ||
		(flag_a_q && !(clr_q[0] || i_vector_ack_a));
	assign flag_b_d = match_b_q ||
		(flag_b_q && !(clr_q[1] || i_vector_ack_b));
	assign flag_ovf_d = ovf_set ||
		(flag_ovf_q && !(clr_q[2] || i_vector_ack_ovf));

	logic loop_en_d;
	logic low_speed_d;
	logic fast_sel_d;
	assign loop_en_d = sysclk_q ? 1'b1 :
		(wr_loop ? i_wdata[`LOOP_ENABLE] : loop_en_q);
	assign low_speed_d = wr_loop ?
		(i_wdata[`LOOP_LOW_SPEED] && !sysclk_q) : low_speed_q;
	assign fast_sel_d = wr_loop ?
		(i_wdata[`LOOP_FAST_SEL] && loop_en_q) : fast_sel_q;

	byte_t rd_gen;
	byte_t rd_mask;
	byte_t rd_flags;
	byte_t rd_loop;
	byte_t rd_mux;
	assign rd_gen = {1'b0, pwm_b_q, mode_b_q, 4'h0};
	assign rd_mask = {1'b0, mask_q[0], mask_q[1], 2'b00, mask_q[2],
		2'b00};
	assign rd_flags = {1'b0, flag_a_q, flag_b_q, 2'b00, flag_ovf_q,
		2'b00};
	assign rd_loop = {low_speed_q, 4'h0, fast_sel_q, loop_en_q,
		locked_q};
	assign rd_mux =
		(i_addr == `ADDR_TIMER_CTRL)   ? ctrl_q  :
		(i_addr == `ADDR_GENERAL_CTRL) ? rd_gen  :
		(i_addr == `ADDR_COUNT)        ? cnt_q   :
		(i_addr == `ADDR_CMP_A)        ? cmp_a_q :
		(i_addr == `ADDR_CMP_B)        ? cmp_b_q :
		(i_addr == `ADDR_CMP_C)        ? cmp_c_q :
		(i_addr == `ADDR_IRQ_MASK)     ? rd_mask :
		(i_addr == `ADDR_IRQ_FLAGS)    ? rd_flags :
		(i_addr == `ADDR_LOOP_CSR)     ? rd_loop : `BYTE_ZERO;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q   <= `BYTE_ZERO;
			pwm_b_q  <= 1'b0;
			mode_b_q <= MODE_DISCONNECT;
			cmp_a_q  <= `BYTE_ZERO;
			cmp_b_q  <= `BYTE_ZERO;
			cmp_c_q  <= `BYTE_ZERO;
			mask_q   <= 3'b000;
			rdata_q  <= `BYTE_ZERO;
		end else begin
			ctrl_q   <= ctrl_d;
			mode_b_q <= mode_b_d;
			if (wr_gen) begin
				pwm_b_q <= i_wdata[`GEN_PWM_B];
			end
			if (wr_cmp_a) begin
				cmp_a_q <= i_wdata;
			end
			if (wr_cmp_b) begin
				cmp_b_q <= i_wdata;
			end
			if (wr_cmp_c) begin
				cmp_c_q <= i_wdata;
			end
			if (wr_mask) begin
				mask_q <= {i_wdata[`IRQ_OVF], i_wdata[`IRQ_CMP_B],
					i_wdata[`IRQ_CMP_A]};
			end
			rdata_q <= i_rd ? rd_mux : `BYTE_ZERO;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q       <= `BYTE_ZERO;
			counted_q   <= 1'b0;
			load_pend_q <= 1'b0;
			load_data_q <= `BYTE_ZERO;
			presc_q     <= `PRESC_ZERO;
			presc_rst_q <= 1'b0;
			half_q      <= 1'b0;
		end else begin
			cnt_q       <= cnt_d;
			counted_q   <= counted_d;
			load_pend_q <= wr_cnt && !fast_sel_q;
			if (wr_cnt) begin
				load_data_q <= i_wdata;
			end
			presc_q     <= presc_d;
			presc_rst_q <= wr_gen && i_wdata[`GEN_PRESC_RST];
			if (i_fast_tick) begin
				half_q <= ~half_q;
			end
		end
	end

	// One stage models the crossing delay between compare and flag.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			match_a_q  <= 1'b0;
			match_b_q  <= 1'b0;
			match_c_q  <= 1'b0;
			ovf_evt_q  <= 1'b0;
			clr_q      <= 3'b000;
			flag_a_q   <= 1'b0;
			flag_b_q   <= 1'b0;
			flag_ovf_q <= 1'b0;
		end else begin
			match_a_q  <= match_a;
			match_b_q  <= match_b;
			match_c_q  <= match_c;
			ovf_evt_q  <= ovf_evt;
			clr_q      <= wr_flags ? {i_wdata[`IRQ_OVF],
				i_wdata[`IRQ_CMP_B], i_wdata[`IRQ_CMP_A]} : 3'b000;
			flag_a_q   <= flag_a_d;
			flag_b_q   <= flag_b_d;
			flag_ovf_q <= flag_ovf_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_a_q   <= 1'b0;
			irq_b_q   <= 1'b0;
			irq_ovf_q <= 1'b0;
		end else begin
			irq_a_q   <= flag_a_q && mask_q[0] && i_global_irq_enable;
			irq_b_q   <= flag_b_q && mask_q[1] && i_global_irq_enable;
			irq_ovf_q <= flag_ovf_q && mask_q[2] &&
				i_global_irq_enable;
		end
	end

	// The lock detector and clock-source strap are analogue-side levels.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			locked_meta_q <= 1'b0;
			locked_q      <= 1'b0;
			sysclk_meta_q <= 1'b0;
			sysclk_q      <= 1'b0;
			loop_en_q     <= 1'b0;
			low_speed_q   <= 1'b0;
			fast_sel_q    <= 1'b0;
		end else begin
			locked_meta_q <= i_loop_locked;
			locked_q      <= locked_meta_q;
			sysclk_meta_q <= i_loop_is_sysclk;
			sysclk_q      <= sysclk_meta_q;
			loop_en_q     <= loop_en_d;
			low_speed_q   <= low_speed_d;
			fast_sel_q    <= fast_sel_d;
		end
	end

	compare_output u_out_a (
		.i_clk    (i_clk),
		.i_rst_n  (i_rst_n),
		.i_mode   (mode_a),
		.i_pwm    (pwm_a),
		.i_match  (match_a),
		.i_force  (force_a),
		.i_bottom (bottom),
		.o_level  (o_compare_a_pin),
		.o_drive  (o_compare_a_oe)
	);

	compare_output u_out_b (
		.i_clk    (i_clk),
		.i_rst_n  (i_rst_n),
		.i_mode   (mode_b_d),
		.i_pwm    (pwm_b_q),
		.i_match  (match_b),
		.i_force  (force_b),
		.i_bottom (bottom),
		.o_level  (o_compare_b_pin),
		.o_drive  (o_compare_b_oe)
	);

	assign o_rdata          = rdata_q;
	assign o_irq_compare_a  = irq_a_q;
	assign o_irq_compare_b  = irq_b_q;
	assign o_irq_overflow   = irq_ovf_q;
	assign o_loop_enable    = loop_en_q;
	assign o_fast_low_speed = low_speed_q;

endmodule : fast_timer

`default_nettype wire

// ===== hdl/fast_timer_pkg.sv
package fast_timer_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [3:0] clock_select_t;

	// Order gives the mode field codes 00, 01, 10, 11.
	typedef enum logic [1:0] {
		MODE_DISCONNECT,
		MODE_TOGGLE,
		MODE_CLEAR,
		MODE_SET
	} compare_mode_t;

endpackage : fast_timer_pkg

// ===== hdl/fast_timer_regs.svh
`ifndef FAST_TIMER_REGS_SVH
`define FAST_TIMER_REGS_SVH

`define ADDR_LOOP_CSR      8'h27
`define ADDR_TIMER_CTRL    8'h30
`define ADDR_GENERAL_CTRL  8'h2c
`define ADDR_COUNT         8'h2f
`define ADDR_CMP_A         8'h2e
`define ADDR_CMP_B         8'h2b
`define ADDR_CMP_C         8'h2d
`define ADDR_IRQ_MASK      8'h39
`define ADDR_IRQ_FLAGS     8'h38

`define CTRL_CLEAR_ON_C    7
`define CTRL_PWM_A         6
`define CTRL_MODE_A_HI     5
`define CTRL_MODE_A_LO     4
`define CTRL_CS_HI         3
`define CTRL_CS_LO         0

`define GEN_PWM_B          6
`define GEN_MODE_B_HI      5
`define GEN_MODE_B_LO      4
`define GEN_FORCE_B        3
`define GEN_FORCE_A        2
`define GEN_PRESC_RST      1

`define IRQ_CMP_A          6
`define IRQ_CMP_B          5
`define IRQ_OVF            2

`define LOOP_LOW_SPEED     7
`define LOOP_FAST_SEL      2
`define LOOP_ENABLE        1
`define LOOP_LOCKED        0

`define BYTE_ZERO          8'h00
`define COUNT_TOP          8'hff
`define COUNT_ONE          8'h01
`define CS_STOP            4'h0
`define CS_ONE             4'h1
`define PRESC_W            14
`define PRESC_ZERO         14'h0000
`define PRESC_ONE          14'h0001

`endif
